// ===== asps_defs.svh
`ifndef ASPS_DEFS_SVH
`define ASPS_DEFS_SVH
`define ASPS_OFF_STATUS 8'h00
`define ASPS_OFF_CTRL1 8'h04
`define ASPS_OFF_CTRL2 8'h08
`define ASPS_OFF_DATA 8'h0C
`define ASPS_OFF_RXINFO 8'h10
`define ASPS_STATUS_RST 8'hC0
`define ASPS_CTRL_RST 8'h00
`define ASPS_C1_R8 7
`define ASPS_C1_T8 6
`define ASPS_C1_NINE 4
`define ASPS_C1_PAR_EN 2
`define ASPS_C1_PAR_ODD 1
`define ASPS_C1_PAR_IE 0
`define ASPS_C2_TXE_IE 7
`define ASPS_C2_TXD_IE 6
`define ASPS_C2_RX_IE 5
`define ASPS_C2_LQ_IE 4
`define ASPS_C2_TX_EN 3
`define ASPS_C2_RX_EN 2
`define ASPS_S_EDGE_A 4'h3
`define ASPS_S_EDGE_B 4'h5
`define ASPS_S_EDGE_C 4'h7
`define ASPS_S_VOTE_A 4'h8
`define ASPS_S_VOTE_B 4'h9
`define ASPS_S_VOTE_C 4'hA
`define ASPS_S_END 4'hF
`define ASPS_RX_LAST8 4'h7
`define ASPS_RX_LAST9 4'h8
`define ASPS_TX_LAST8 4'h9
`define ASPS_TX_LAST9 4'hA
`define ASPS_QUIET8 8'hA0
`define ASPS_QUIET9 8'hB0
`endif

// ===== asps_pkg.sv
package asps_pkg;
   typedef struct packed {
      logic tx_empty_flag;
      logic transmit_done_flag;
      logic rx_full_flag;
      logic line_quiet_flag;
      logic overrun_flag;
      logic noise_flag;
      logic frame_err_flag;
      logic parity_error_flag;
   } asps_status_s;
   typedef struct packed {
      logic t8;
      logic nine_bit_select;
      logic parity_enable;
      logic parity_odd_select;
      logic parity_irq_enable;
   } asps_ctrl1_s;
   typedef struct packed {
      logic tx_empty_irq_enable;
      logic tx_done_irq_enable;
      logic receive_irq_enable;
      logic line_quiet_irq_enable;
      logic tx_en;
      logic rx_en;
   } asps_ctrl2_s;
   typedef struct packed {
      logic nine;
      logic par_en;
      logic par_odd;
   } asps_fmt_s;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } asps_rx_state_e;
   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_SHIFT = 1'b1
   } asps_tx_state_e;
endpackage : asps_pkg

// ===== asps_remote.sv
`timescale 1ns/1ps
module asps_remote (
   input wire logic clk_i,
   input wire logic baud16_i,
   input wire logic txd_i,
   output logic rxd_o
);
   initial rxd_o = 1'b1;
   task automatic tick;
      do @(posedge clk_i); while (baud16_i !== 1'b1);
   endtask : tick
   // zero timing error: every bit lasts exactly sixteen strobes
   task automatic send(input logic [8:0] w, input int n, input int flip);
      logic [10:0] f;
      int j;
      f = {2'b11, w} << 1;
      f[n + 1] = 1'b1;
      for (j = 0; j < (n + 2) * 16; j++) begin
         tick();
         // one flipped sample 8 keeps the majority; flip -1 hits start
         rxd_o <= f[j / 16] ^ (j / 16 == flip + 1 && j % 16 == 8);
      end
      // line stays high afterwards so the next start edge qualifies
      repeat (5) tick();
   endtask : send
   task automatic grab(input int n, output logic [8:0] w,
                       output logic stp);
      int k;
      w = 9'h000;
      do @(posedge clk_i); while (txd_i !== 1'b0);
      repeat (8) tick();
      for (k = 0; k <= n; k++) begin
         repeat (16) tick();
         if (k < n) w[k] = txd_i;
         else stp = txd_i;
      end
   endtask : grab
endmodule : asps_remote

// ===== asps_serial.sv
`timescale 1ns/1ps
`include "asps_defs.svh"
module asps_serial (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic baud16_i,
   input wire logic rxd_i,
   output logic txd_o,
   input wire logic halt_i,
   input wire logic global_mask_i,
   output logic irq_o,
   output logic wait_wake_o
);
   import asps_pkg::*;

   asps_status_s st;
   asps_ctrl1_s c1;
   asps_ctrl2_s c2;
   logic [7:0] tdr;
   logic [7:0] rdr;
   logic r8;
   logic addr_mark;
   logic status_seen;
   logic bus_req;
   logic bus_rd;
   logic bus_wr;
   logic data_wr;
   logic clr_rx;
   logic clr_tdone;
   logic [31:0] rd_val;
   logic tick;

   // halt stops the sample strobe, so both engines hold their place
   assign tick = baud16_i & ~halt_i;

   // wishbone classic slave, answers one cycle after the request
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_rd = bus_req & ~wb_we_i;
   assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
   assign data_wr = bus_wr & (wb_adr_i == `ASPS_OFF_DATA);
   assign clr_rx = bus_rd & (wb_adr_i == `ASPS_OFF_DATA) & status_seen;
   assign clr_tdone = data_wr & status_seen;

   always_comb begin
      rd_val = 32'h0000_0000;
      case (wb_adr_i)
         `ASPS_OFF_STATUS: rd_val[7:0] = st;
         `ASPS_OFF_CTRL1: begin
            rd_val[`ASPS_C1_R8] = r8;
            rd_val[`ASPS_C1_T8] = c1.t8;
            rd_val[`ASPS_C1_NINE] = c1.nine_bit_select;
            rd_val[`ASPS_C1_PAR_EN] = c1.parity_enable;
            rd_val[`ASPS_C1_PAR_ODD] = c1.parity_odd_select;
            rd_val[`ASPS_C1_PAR_IE] = c1.parity_irq_enable;
         end
         `ASPS_OFF_CTRL2: begin
            rd_val[`ASPS_C2_TXE_IE] = c2.tx_empty_irq_enable;
            rd_val[`ASPS_C2_TXD_IE] = c2.tx_done_irq_enable;
            rd_val[`ASPS_C2_RX_IE] = c2.receive_irq_enable;
            rd_val[`ASPS_C2_LQ_IE] = c2.line_quiet_irq_enable;
            rd_val[`ASPS_C2_TX_EN] = c2.tx_en;
            rd_val[`ASPS_C2_RX_EN] = c2.rx_en;
         end
         `ASPS_OFF_DATA: rd_val[7:0] = rdr;
         `ASPS_OFF_RXINFO: rd_val[0] = addr_mark;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         status_seen <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_rd) begin
            wb_dat_o <= rd_val;
         end
         if (bus_rd && wb_adr_i == `ASPS_OFF_STATUS) begin
            status_seen <= 1'b1;
         end else if ((bus_rd || bus_wr) && wb_adr_i == `ASPS_OFF_DATA) begin
            status_seen <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c1 <= asps_ctrl1_s'(5'h00);
         c2 <= asps_ctrl2_s'(6'h00);
         tdr <= `ASPS_CTRL_RST;
      end else if (bus_wr) begin
         case (wb_adr_i)
            `ASPS_OFF_CTRL1: begin
               c1.t8 <= wb_dat_i[`ASPS_C1_T8];
               c1.nine_bit_select <= wb_dat_i[`ASPS_C1_NINE];
               c1.parity_enable <= wb_dat_i[`ASPS_C1_PAR_EN];
               c1.parity_odd_select <= wb_dat_i[`ASPS_C1_PAR_ODD];
               c1.parity_irq_enable <= wb_dat_i[`ASPS_C1_PAR_IE];
            end
            `ASPS_OFF_CTRL2: begin
               c2.tx_empty_irq_enable <= wb_dat_i[`ASPS_C2_TXE_IE];
               c2.tx_done_irq_enable <= wb_dat_i[`ASPS_C2_TXD_IE];
               c2.receive_irq_enable <= wb_dat_i[`ASPS_C2_RX_IE];
               c2.line_quiet_irq_enable <= wb_dat_i[`ASPS_C2_LQ_IE];
               c2.tx_en <= wb_dat_i[`ASPS_C2_TX_EN];
               c2.rx_en <= wb_dat_i[`ASPS_C2_RX_EN];
            end
            `ASPS_OFF_DATA: tdr <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   // transmitter
   asps_tx_state_e tx_state;
   asps_fmt_s tx_fmt;
   logic [3:0] tx_cnt;
   logic [3:0] tx_idx;
   logic [10:0] tx_shift;
   logic [8:0] tx_word;
   logic [10:0] tx_frame;
   logic tx_load;
   logic tx_fin;
   logic [3:0] tx_last;

   always_comb begin
      tx_word = {c1.t8, tdr};
      if (c1.parity_enable) begin
         if (c1.nine_bit_select) begin
            tx_word[8] = ^tdr[7:0] ^ c1.parity_odd_select;
         end else begin
            tx_word[7] = ^tdr[6:0] ^ c1.parity_odd_select;
         end
      end
   end
   // written msb slot is overwritten by parity above
   assign tx_frame = c1.nine_bit_select ? {1'b1, tx_word, 1'b0}
                                        : {2'b11, tx_word[7:0], 1'b0};
   assign tx_last = tx_fmt.nine ? `ASPS_TX_LAST9 : `ASPS_TX_LAST8;
   assign tx_load = (tx_state == TX_IDLE) & c2.tx_en & ~st.tx_empty_flag
                    & ~halt_i;
   assign tx_fin = tick & (tx_state == TX_SHIFT) & (tx_cnt == `ASPS_S_END)
                   & (tx_idx == tx_last);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_state <= TX_IDLE;
         tx_fmt <= asps_fmt_s'(3'h0);
         tx_cnt <= 4'h0;
         tx_idx <= 4'h0;
         tx_shift <= 11'h7FF;
         txd_o <= 1'b1;
      end else if (!c2.tx_en) begin
         tx_state <= TX_IDLE;
         txd_o <= 1'b1;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               txd_o <= 1'b1;
               if (tx_load) begin
                  // format is frozen per frame
                  tx_fmt <= '{c1.nine_bit_select, c1.parity_enable,
                              c1.parity_odd_select};
                  tx_shift <= tx_frame;
                  tx_cnt <= 4'h0;
                  tx_idx <= 4'h0;
                  tx_state <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               txd_o <= tx_shift[0];
               if (tick) begin
                  tx_cnt <= tx_cnt + 4'h1;
                  if (tx_cnt == `ASPS_S_END) begin
                     tx_shift <= {1'b1, tx_shift[10:1]};
                     tx_idx <= tx_idx + 4'h1;
                     if (tx_idx == tx_last) begin
                        tx_state <= TX_IDLE;
                     end
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // receiver
   asps_rx_state_e rx_state;
   asps_fmt_s rx_fmt;
   logic [3:0] rx_cnt;
   logic [3:0] rx_idx;
   logic [2:0] rx_hist;
   logic v8;
   logic v9;
   logic [8:0] rx_word;
   logic noise_pend;
   logic maj;
   logic split;
   logic rx_fin;
   logic [8:0] rx_data9;
   logic rx_par_bad;
   logic rx_msb;
   logic [3:0] rx_last;

   assign maj = (v8 & v9) | (v8 & rxd_i) | (v9 & rxd_i);
   assign split = ~((v8 == v9) & (v9 == rxd_i));
   assign rx_last = rx_fmt.nine ? `ASPS_RX_LAST9 : `ASPS_RX_LAST8;
   assign rx_fin = tick & c2.rx_en & (rx_state == RX_STOP)
                   & (rx_cnt == `ASPS_S_VOTE_C);
   assign rx_data9 = rx_fmt.nine ? rx_word : {1'b0, rx_word[8:1]};
   assign rx_par_bad = rx_fmt.par_en & ((rx_fmt.nine ? ^rx_word
                       : ^rx_word[8:1]) != rx_fmt.par_odd);
   // the parity slot sits at word[8] when enabled, so skip it
   assign rx_msb = rx_fmt.par_en ? rx_word[7] : rx_word[8];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_state <= RX_IDLE;
         rx_fmt <= asps_fmt_s'(3'h0);
         rx_cnt <= 4'h0;
         rx_idx <= 4'h0;
         rx_hist <= 3'h0;
         v8 <= 1'b0;
         v9 <= 1'b0;
         rx_word <= 9'h000;
         noise_pend <= 1'b0;
      end else if (!c2.rx_en) begin
         rx_state <= RX_IDLE;
         rx_hist <= 3'h0;
         noise_pend <= 1'b0;
      end else if (tick) begin
         if (rx_cnt == `ASPS_S_VOTE_A) begin
            v8 <= rxd_i;
         end
         if (rx_cnt == `ASPS_S_VOTE_B) begin
            v9 <= rxd_i;
         end
         case (rx_state)
            RX_IDLE: begin
               rx_hist <= {rx_hist[1:0], rxd_i};
               if (!rxd_i) begin
                  rx_state <= RX_START;
                  // the edge tick is sample zero, the next one sample one
                  rx_cnt <= 4'h1;
                  rx_fmt <= '{c1.nine_bit_select, c1.parity_enable,
                              c1.parity_odd_select};
                  if (rx_hist != 3'h7) begin
                     noise_pend <= 1'b1;
                  end
               end
            end
            RX_START: begin
               rx_cnt <= rx_cnt + 4'h1;
               if (rxd_i && (rx_cnt == `ASPS_S_EDGE_A
                   || rx_cnt == `ASPS_S_EDGE_B
                   || rx_cnt == `ASPS_S_EDGE_C)) begin
                  noise_pend <= 1'b1;
               end
               if (rxd_i && rx_cnt >= `ASPS_S_VOTE_A
                   && rx_cnt <= `ASPS_S_VOTE_C) begin
                  noise_pend <= 1'b1;
               end
               if (rx_cnt == `ASPS_S_VOTE_C) begin
                  if (maj) begin
                     // false start: dropped, noise kept for next frame
                     rx_state <= RX_IDLE;
                     rx_hist <= 3'h0;
                     noise_pend <= 1'b1;
                  end
               end
               if (rx_cnt == `ASPS_S_END) begin
                  rx_state <= RX_DATA;
                  rx_idx <= 4'h0;
               end
            end
            RX_DATA: begin
               rx_cnt <= rx_cnt + 4'h1;
               if (rx_cnt == `ASPS_S_VOTE_C) begin
                  rx_word <= {maj, rx_word[8:1]};
                  if (split) begin
                     noise_pend <= 1'b1;
                  end
               end
               if (rx_cnt == `ASPS_S_END) begin
                  rx_idx <= rx_idx + 4'h1;
                  if (rx_idx == rx_last) begin
                     rx_state <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               rx_cnt <= rx_cnt + 4'h1;
               // finish at mid stop bit so the next edge is not missed
               if (rx_cnt == `ASPS_S_VOTE_C) begin
                  rx_state <= RX_IDLE;
                  rx_hist <= 3'h0;
                  noise_pend <= 1'b0;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdr <= 8'h00;
         r8 <= 1'b0;
         addr_mark <= 1'b0;
      end else if (rx_fin && !st.rx_full_flag) begin
         rdr <= rx_data9[7:0];
         r8 <= rx_data9[8];
         addr_mark <= rx_msb;
      end
   end

   // line quiet: one frame time of idle high, re-armed by a reception
   logic [7:0] quiet_cnt;
   logic quiet_armed;
   logic quiet_hit;
   logic [7:0] quiet_len;

   assign quiet_len = c1.nine_bit_select ? `ASPS_QUIET9 : `ASPS_QUIET8;
   assign quiet_hit = quiet_armed & (quiet_cnt == quiet_len);

   always_ff @(posedge clk_i) begin
      if (rst_i || !c2.rx_en) begin
         quiet_cnt <= 8'h00;
         quiet_armed <= 1'b0;
      end else begin
         if (rx_fin && !st.rx_full_flag) begin
            quiet_armed <= 1'b1;
         end else if (quiet_hit) begin
            quiet_armed <= 1'b0;
         end
         if (tick) begin
            if (rx_state != RX_IDLE || !rxd_i) begin
               quiet_cnt <= 8'h00;
            end else if (quiet_cnt != quiet_len) begin
               quiet_cnt <= quiet_cnt + 8'h01;
            end
         end
      end
   end

   // flags: a set in the same cycle as a clear wins, except a frame ending as rx_full_flag is cleared sets only overrun_flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= asps_status_s'(`ASPS_STATUS_RST);
      end else begin
         st.tx_empty_flag <= (st.tx_empty_flag & ~data_wr) | tx_load;
         st.transmit_done_flag <= (st.transmit_done_flag & ~clr_tdone)
                                  | tx_fin;
         st.rx_full_flag <= (st.rx_full_flag & ~clr_rx)
                            | (rx_fin & ~st.rx_full_flag);
         st.overrun_flag <= (st.overrun_flag & ~clr_rx)
                            | (rx_fin & st.rx_full_flag);
         st.noise_flag <= (st.noise_flag & ~clr_rx)
                          | (rx_fin & ~st.rx_full_flag & (noise_pend | split));
         st.frame_err_flag <= (st.frame_err_flag & ~clr_rx)
                              | (rx_fin & ~st.rx_full_flag & ~maj);
         st.parity_error_flag <= (st.parity_error_flag & ~clr_rx)
                                 | (rx_fin & ~st.rx_full_flag & rx_par_bad);
         st.line_quiet_flag <= (st.line_quiet_flag & ~clr_rx) | quiet_hit;
      end
   end

   logic irq_ev;
   // noise and framing flags are left out on purpose
   assign irq_ev = (st.tx_empty_flag & c2.tx_empty_irq_enable)
      | (st.transmit_done_flag & c2.tx_done_irq_enable)
      | ((st.rx_full_flag | st.overrun_flag)
         & c2.receive_irq_enable)
      | (st.line_quiet_flag & c2.line_quiet_irq_enable)
      | (st.parity_error_flag & c1.parity_irq_enable);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         wait_wake_o <= 1'b0;
      end else begin
         irq_o <= irq_ev & ~global_mask_i;
         wait_wake_o <= irq_ev & ~global_mask_i & ~halt_i;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_tx_parity;
      tx_load && c1.parity_enable && !c1.nine_bit_select |=>
         tx_shift[8] == (^tx_shift[7:1] ^ tx_fmt.par_odd);
   endproperty
   a_tx_parity: assert property (p_tx_parity)
      else $error("parity bit wrong in transmit frame");

   property p_no_parity_err;
      rx_fin && !rx_fmt.par_en |=> !$rose(st.parity_error_flag);
   endproperty
   a_no_parity_err: assert property (p_no_parity_err)
      else $error("parity error raised with parity off");

   property p_data_noise;
      tick && c2.rx_en && rx_state == RX_DATA
         && rx_cnt == `ASPS_S_VOTE_C && split |=> noise_pend;
   endproperty
   a_data_noise: assert property (p_data_noise)
      else $error("split data samples did not mark noise");

   property p_data_vote;
      tick && c2.rx_en && rx_state == RX_DATA && rx_cnt == `ASPS_S_VOTE_C
         |=> rx_word[8] == $past(maj);
   endproperty
   a_data_vote: assert property (p_data_vote)
      else $error("data bit is not the sample majority");

   property p_bad_edge;
      tick && c2.rx_en && rx_state == RX_IDLE && !rxd_i
         && rx_hist != 3'h7 |=> noise_pend && rx_state == RX_START
         && rx_cnt == 4'h1;
   endproperty
   a_bad_edge: assert property (p_bad_edge)
      else $error("invalid start edge not handled");

   property p_start_high;
      tick && c2.rx_en && rx_state == RX_START
         && rx_cnt == `ASPS_S_VOTE_A && rxd_i |=> noise_pend;
   endproperty
   a_start_high: assert property (p_start_high)
      else $error("high start sample did not mark noise");

   property p_halt_freeze;
      halt_i |=> $stable(rx_cnt) && $stable(tx_cnt) && $stable(tx_state);
   endproperty
   a_halt_freeze: assert property (p_halt_freeze)
      else $error("serial engine moved during halt");

   property p_halt_no_wake;
      halt_i |=> !wait_wake_o;
   endproperty
   a_halt_no_wake: assert property (p_halt_no_wake)
      else $error("wake raised during halt");

   property p_parity_irq;
      st.parity_error_flag && c1.parity_irq_enable && !global_mask_i
         |=> irq_o;
   endproperty
   a_parity_irq: assert property (p_parity_irq)
      else $error("parity error did not interrupt");

   property p_overrun;
      rx_fin && st.rx_full_flag |=> st.overrun_flag && $stable(rdr);
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged or data lost");

   property p_fmt_hold;
      rx_state == RX_DATA |=> $stable(rx_fmt);
   endproperty
   a_fmt_hold: assert property (p_fmt_hold)
      else $error("receive format changed mid frame");

endmodule : asps_serial

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   logic clk_i;
   logic rst_i;
   logic wb_cyc, wb_stb, wb_we, rxd, txd_o, halt, mask;
   logic wb_ack_o, irq_o, wait_wake_o;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat, wb_dat_o;
   logic [1:0] bcnt = 2'h0;
   logic baud16 = 1'b0;
   int n_mismatch, n_checks, cycles;

   asps_serial dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .baud16_i(baud16), .rxd_i(rxd),
      .txd_o(txd_o), .halt_i(halt), .global_mask_i(mask),
      .irq_o(irq_o), .wait_wake_o(wait_wake_o));
   asps_remote rem (.clk_i(clk_i), .baud16_i(baud16), .txd_i(txd_o),
      .rxd_o(rxd));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // one strobe every fourth clock keeps frames short
   always @(posedge clk_i) begin
      bcnt <= bcnt + 2'h1;
      baud16 <= (bcnt == 2'h3);
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      if (n_mismatch == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= {24'h000000, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb

   function automatic logic [8:0] enc(input logic [8:0] w, input int n,
                                      input logic pe, input logic po);
      logic [8:0] m;
      m = w & ((9'h001 << n) - 9'h001);
      if (pe) m[n - 1] = ^(m & ((9'h001 << (n - 1)) - 9'h001)) ^ po;
      return m;
   endfunction : enc

   initial begin
      logic [7:0] q;
      logic [8:0] w, e, g;
      logic t8, stp, nine, pe, po, bad;
      int i, n, flip;
      {wb_cyc, wb_stb, wb_we, halt, mask} = 5'h00;
      wb_adr = 8'h00;
      wb_sel = 4'hF;
      wb_dat = 32'h0;
      rst_i = 1'b1;
      void'($urandom(67547));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, 8'h00, 8'h00, q);
      `CHK(q, 8'hC0)
      wb(0, 8'h14, 8'h00, q);
      `CHK(q, 8'h00)
      wb(1, 8'h08, 8'h8C, q);
      repeat (3) @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      `CHK(wait_wake_o, 1'b1)
      mask <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      mask <= 1'b0;
      halt <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(wait_wake_o, 1'b0)
      halt <= 1'b0;
      wb(1, 8'h08, 8'h2C, q);
      for (i = 0; i < 10; i++) begin
         {nine, pe, po, t8} = 4'($urandom);
         n = nine ? 9 : 8;
         w = 9'($urandom);
         wb(1, 8'h04, {1'b0, t8, 1'b0, nine, 1'b0, pe, po, 1'b1}, q);
         e = enc({t8, w[7:0]}, n, pe, po);
         halt <= (i == 0);
         fork
            begin
               wb(1, 8'h0C, w[7:0], q);
               repeat (100) @(posedge clk_i);
               if (i == 0) `CHK(txd_o, 1'b1)
               halt <= 1'b0;
            end
            rem.grab(n, g, stp);
         join
         `CHK(g, e)
         `CHK(stp, 1'b1)
         bad = pe & 1'($urandom);
         // -2 leaves every sample clean, -1 disturbs the start bit
         flip = int'($urandom % (n + 1)) - 1;
         if ($urandom % 3 != 0) flip = -2;
         if (i == 2) flip = -1;
         e = enc(9'($urandom), n, pe, po);
         e[n - 1] = e[n - 1] ^ bad;
         rem.send(e, n, flip);
         // a second word before the read must not replace the first
         if (i == 1) rem.send(enc(9'($urandom), n, pe, po), n, -2);
         `CHK(irq_o, 1'b1)
         wb(0, 8'h00, 8'h00, q);
         `CHK(q[5], 1'b1)
         `CHK(q[3], i == 1)
         `CHK(q[0], bad)
         `CHK(q[2], flip >= -1)
         wb(0, 8'h04, 8'h00, q);
         if (nine) `CHK(q[7], e[8])
         wb(0, 8'h10, 8'h00, q);
         `CHK(q[0], e[n - 1 - int'(pe)])
         wb(0, 8'h0C, 8'h00, q);
         `CHK(q, e[7:0])
         repeat (2) @(posedge clk_i);
         `CHK(irq_o, 1'b0)
      end
      report_and_stop();
   end
endmodule : tb_top
